// ==== src/sstd_map.vh ====
// Purpose: Constants for the shift, subtract and table access datapath
// Assumes: 16-bit data word, 24-bit program word
// Notes: Operation codes are binary selects from the decoder
`ifndef SSTD_MAP_VH
`define SSTD_MAP_VH
// Operation select codes
`define SSTD_OP_NONE 4'h0
`define SSTD_OP_SHL_REG 4'h1
`define SSTD_OP_SHL_LIT 4'h2
`define SSTD_OP_BSUB_F 4'h3
`define SSTD_OP_BSUB_L10 4'h4
`define SSTD_OP_BSUB_L5 4'h5
`define SSTD_OP_RBSUB_F 4'h6
`define SSTD_OP_RBSUB_L5 4'h7
`define SSTD_OP_TRD_HI 4'h8
`define SSTD_OP_TRD_LO 4'h9
`define SSTD_OP_TWR_HI 4'ha
`define SSTD_OP_TWR_LO 4'hb
// Cycle counts of the table operations and the base single-cycle count
`define SSTD_CYC_TBL_RD 3'h5
`define SSTD_CYC_TBL_WR 3'h2
`define SSTD_CYC_BASE 3'h1
// Status flag field positions
`define SSTD_FLAG_C 0
`define SSTD_FLAG_Z 1
`define SSTD_FLAG_OVF 2
`define SSTD_FLAG_N 3
`define SSTD_FLAG_DIG 4
`define SSTD_FLAGS_RST 5'h00
`endif

// ==== src/sstd_sub_unit.v ====
// Purpose: Subtract-with-borrow arithmetic with full flag set
// Assumes: Operands already selected and ordered by the caller
// Notes: Purely combinational
`timescale 1ns/10ps
`include "sstd_map.vh"
module sstd_sub_unit #(
   parameter WIDTH = 16
) (
   input wire [WIDTH-1:0] min_i, // Minuend
   input wire [WIDTH-1:0] sub_i, // Subtrahend
   input wire carry_i, // Carry in, inverted gives borrow
   output wire [WIDTH-1:0] diff_o, // Difference
   output wire [4:0] flags_o // Digit carry, N, overflow, Z, C
);
   wire [WIDTH:0] sum;
   wire [4:0] low_sum;
   // Add of ones complement: carry out set means no borrow
   assign sum = {1'b0, min_i} + {1'b0, ~sub_i} + {{WIDTH{1'b0}}, carry_i};
   assign low_sum = {1'b0, min_i[3:0]} + {1'b0, ~sub_i[3:0]} + {4'h0, carry_i};
   assign diff_o = sum[WIDTH-1:0];
   // Overflow when operand signs differ and result sign follows subtrahend
   assign flags_o[`SSTD_FLAG_C] = sum[WIDTH];
   assign flags_o[`SSTD_FLAG_Z] = (sum[WIDTH-1:0] == {WIDTH{1'b0}});
   assign flags_o[`SSTD_FLAG_OVF] = (min_i[WIDTH-1] ^ sub_i[WIDTH-1]) &
                                   (min_i[WIDTH-1] ^ sum[WIDTH-1]);
   assign flags_o[`SSTD_FLAG_N] = sum[WIDTH-1];
   assign flags_o[`SSTD_FLAG_DIG] = low_sum[4];
endmodule

// ==== src/sstd_datapath.v ====
// Purpose: Shift, subtract-with-borrow and table access execution datapath
// Assumes: Decoder supplies op and operands in the cycle op_valid_i is high
// Notes: One operation in flight; busy_o holds off the decoder
`timescale 1ns/10ps
`include "sstd_map.vh"
module sstd_datapath #(
   parameter WIDTH = 16,
   parameter PWIDTH = 24
) (
   input wire ref_clk_i, // Instruction clock
   input wire rst_i, // Synchronous reset, high
   input wire ce_i, // Clock enable, freezes state when low
   input wire op_valid_i, // Operation offered this cycle
   input wire [3:0] op_i, // Operation select
   input wire periph_i, // Operand is a peripheral register
   input wire [WIDTH-1:0] opa_i, // Base register, file value or source
   input wire [WIDTH-1:0] opb_i, // Count register or default register
   input wire [9:0] lit_i, // Literal field
   input wire [4:0] flags_i, // Current status flags
   input wire [PWIDTH-1:0] prog_rdata_i, // Program memory read word
   output wire busy_o, // Operation in progress
   output reg done_o, // Result cycle pulse
   output reg wr_en_o, // Register write strobe
   output reg [WIDTH-1:0] result_o, // Register write data
   output reg [4:0] flags_o, // New status flags
   output reg [4:0] flags_we_o, // Flag update mask
   output reg prog_we_o, // Program latch write strobe
   output reg [PWIDTH-1:0] prog_wdata_o, // Program latch data
   output reg [PWIDTH-1:0] prog_wmask_o // Program latch bit mask
);
   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;
   localparam [4:0] FLAGS_ALL = 5'h1f;
   localparam [4:0] FLAGS_NZ = 5'h0a;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] cnt;
   reg [2:0] next_cnt;
   reg [3:0] op;
   reg [WIDTH-1:0] hold_a;
   reg [WIDTH-1:0] hold_res;
   reg [4:0] hold_flags;
   reg [4:0] hold_we;
   reg hold_wr;
   reg [WIDTH-1:0] sub_min;
   reg [WIDTH-1:0] sub_sub;
   wire [WIDTH-1:0] diff;
   wire [4:0] sub_flags;
   reg [WIDTH-1:0] shl_res;
   reg [WIDTH-1:0] calc_res;
   reg [4:0] calc_flags;
   reg [4:0] calc_we;
   reg calc_wr;
   reg [2:0] calc_cyc;

   // Cycle count of an operation, with peripheral surcharge
   function [2:0] op_cycles;
      input [3:0] code;
      input periph;
      begin
         case (code)
            `SSTD_OP_TRD_HI, `SSTD_OP_TRD_LO: op_cycles = `SSTD_CYC_TBL_RD;
            `SSTD_OP_TWR_HI, `SSTD_OP_TWR_LO: op_cycles = `SSTD_CYC_TBL_WR;
            `SSTD_OP_BSUB_F, `SSTD_OP_RBSUB_F:
               op_cycles = `SSTD_CYC_BASE + {2'b00, periph};
            default: op_cycles = `SSTD_CYC_BASE;
         endcase
      end
   endfunction

   // Left shift: zero fill, overflowing bits dropped, carry untouched
   function [WIDTH-1:0] shl;
      input [WIDTH-1:0] val;
      input [4:0] amt;
      begin
         shl = val << amt;
      end
   endfunction

   // Operand steering for the subtractor
   always @* begin
      case (op_i)
         `SSTD_OP_BSUB_F: begin
            sub_min = opa_i;
            sub_sub = opb_i;
         end
         `SSTD_OP_BSUB_L10: begin
            sub_min = opa_i;
            sub_sub = {{(WIDTH-10){1'b0}}, lit_i};
         end
         `SSTD_OP_BSUB_L5: begin
            sub_min = opa_i;
            sub_sub = {{(WIDTH-5){1'b0}}, lit_i[4:0]};
         end
         `SSTD_OP_RBSUB_F: begin
            sub_min = opb_i;
            sub_sub = opa_i;
         end
         `SSTD_OP_RBSUB_L5: begin
            sub_min = {{(WIDTH-5){1'b0}}, lit_i[4:0]};
            sub_sub = opa_i;
         end
         default: begin
            sub_min = opa_i;
            sub_sub = opb_i;
         end
      endcase
   end

   sstd_sub_unit #(
      .WIDTH(WIDTH)
   ) u_sub (
      .min_i(sub_min),
      .sub_i(sub_sub),
      .carry_i(flags_i[`SSTD_FLAG_C]),
      .diff_o(diff),
      .flags_o(sub_flags)
   );

   // Result, flag and write-enable selection per operation
   always @* begin
      shl_res = shl(opa_i, (op_i == `SSTD_OP_SHL_REG) ? opb_i[4:0] : lit_i[4:0]);
      calc_res = diff;
      calc_flags = sub_flags;
      calc_we = FLAGS_ALL;
      calc_wr = 1'b1;
      calc_cyc = op_cycles(op_i, periph_i);
      case (op_i)
         `SSTD_OP_SHL_REG, `SSTD_OP_SHL_LIT: begin
            calc_res = shl_res;
            calc_flags = {1'b0, shl_res[WIDTH-1], 1'b0,
                          (shl_res == {WIDTH{1'b0}}), 1'b0};
            calc_we = FLAGS_NZ;
         end
         `SSTD_OP_BSUB_F, `SSTD_OP_BSUB_L10, `SSTD_OP_BSUB_L5,
         `SSTD_OP_RBSUB_F, `SSTD_OP_RBSUB_L5: begin
            calc_res = diff;
         end
         `SSTD_OP_TRD_HI: begin
            calc_res = {{(WIDTH-8){1'b0}}, prog_rdata_i[23:16]};
            calc_we = 5'h00;
         end
         `SSTD_OP_TRD_LO: begin
            calc_res = prog_rdata_i[15:0];
            calc_we = 5'h00;
         end
         `SSTD_OP_TWR_HI, `SSTD_OP_TWR_LO: begin
            calc_we = 5'h00;
            calc_wr = 1'b0;
         end
         default: begin
            calc_we = 5'h00;
            calc_wr = 1'b0;
         end
      endcase
   end

   // Sequencer: multi-cycle operations park here until their last cycle
   always @* begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         ST_IDLE: begin
            if (op_valid_i && calc_cyc > 3'h1) begin
               next_state = ST_WAIT;
               next_cnt = calc_cyc - 3'h1;
            end
         end
         ST_WAIT: begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h1) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   assign busy_o = (state == ST_WAIT);

   // Registered outputs; table reads sample memory on their final cycle
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         op <= `SSTD_OP_NONE;
         hold_a <= 16'h0000;
         hold_res <= 16'h0000;
         hold_flags <= `SSTD_FLAGS_RST;
         hold_we <= 5'h00;
         hold_wr <= 1'b0;
         done_o <= 1'b0;
         wr_en_o <= 1'b0;
         result_o <= 16'h0000;
         flags_o <= `SSTD_FLAGS_RST;
         flags_we_o <= 5'h00;
         prog_we_o <= 1'b0;
         prog_wdata_o <= 24'h000000;
         prog_wmask_o <= 24'h000000;
      end else if (ce_i) begin
         state <= next_state;
         cnt <= next_cnt;
         done_o <= 1'b0;
         wr_en_o <= 1'b0;
         flags_we_o <= 5'h00;
         prog_we_o <= 1'b0;
         if (state == ST_IDLE && op_valid_i) begin
            op <= op_i;
            hold_a <= opa_i;
            hold_res <= calc_res;
            hold_flags <= calc_flags;
            hold_we <= calc_we;
            hold_wr <= calc_wr;
            if (calc_cyc == 3'h1) begin
               done_o <= 1'b1;
               wr_en_o <= calc_wr;
               result_o <= calc_res;
               flags_o <= calc_flags;
               flags_we_o <= calc_we;
            end
         end else if (state == ST_WAIT && cnt == 3'h1) begin
            done_o <= 1'b1;
            wr_en_o <= hold_wr;
            flags_we_o <= hold_we;
            flags_o <= hold_flags;
            result_o <= hold_res;
            case (op)
               `SSTD_OP_TRD_HI: begin
                  result_o <= {{(WIDTH-8){1'b0}}, prog_rdata_i[23:16]};
               end
               `SSTD_OP_TRD_LO: begin
                  result_o <= prog_rdata_i[15:0];
               end
               `SSTD_OP_TWR_HI: begin
                  prog_we_o <= 1'b1;
                  prog_wdata_o <= {hold_a[7:0], 16'h0000};
                  prog_wmask_o <= 24'hff0000;
               end
               `SSTD_OP_TWR_LO: begin
                  prog_we_o <= 1'b1;
                  prog_wdata_o <= {8'h00, hold_a};
                  prog_wmask_o <= 24'h00ffff;
               end
               default: begin
                  prog_we_o <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ==== bench/sstd_datapath_properties.sv ====
// Purpose: Timing and result properties of the shift, subtract and table datapath
// Assumes: Clock enable high whenever an operation is taken
// Notes: Sees only the top module ports
`timescale 1ns/10ps
`include "sstd_map.vh"
module sstd_datapath_checker #(
   parameter WIDTH = 16,
   parameter PWIDTH = 24
) (
   input wire ref_clk_i, // Clock
   input wire rst_i, // Reset
   input wire ce_i, // Enable
   input wire op_valid_i, // Offer
   input wire [3:0] op_i, // Op
   input wire periph_i, // Peripheral
   input wire [15:0] opa_i, // A
   input wire [15:0] opb_i, // B
   input wire [9:0] lit_i, // Literal
   input wire [4:0] flags_i, // Flags in
   input wire [23:0] prog_rdata_i, // Prog read
   input wire busy_o, // Busy
   input wire done_o, // Done
   input wire wr_en_o, // Write
   input wire [15:0] result_o, // Result
   input wire [4:0] flags_o, // Flags
   input wire [4:0] flags_we_o, // Flag mask
   input wire prog_we_o, // Prog write
   input wire [23:0] prog_wdata_o, // Prog data
   input wire [23:0] prog_wmask_o // Prog mask
);
   // Take condition and reference differences, kept as nets so $past sees plain signals
   wire tk = ce_i && op_valid_i && !busy_o;
   wire [16:0] d5 = {1'b0, opa_i} - {12'h000, lit_i[4:0]} - {16'h0000, ~flags_i[0]};
   wire [15:0] r5 = d5[15:0];
   wire b5 = d5[16];
   wire [15:0] d10 = opa_i - {6'h00, lit_i} - {15'h0000, ~flags_i[0]};
   wire [16:0] d7 = {12'h000, lit_i[4:0]} - {1'b0, opa_i} - {16'h0000, ~flags_i[0]};
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   AST_SHL_REG: assert property (tk && op_i == `SSTD_OP_SHL_REG |=> done_o && wr_en_o
      && flags_we_o == 5'h0a && result_o == ($past(opa_i) << $past(opb_i[4:0])))
      else $error("shift by register wrong");
   AST_SHL_LIT: assert property (tk && op_i == `SSTD_OP_SHL_LIT |=> done_o && wr_en_o
      && flags_we_o == 5'h0a && result_o == ($past(opa_i) << $past(lit_i[4:0])))
      else $error("shift by literal wrong");
   AST_BSUB_L10: assert property (tk && op_i == `SSTD_OP_BSUB_L10 |=> done_o
      && flags_we_o == 5'h1f && result_o == $past(d10)) else $error("long literal subtract wrong");
   AST_BSUB_L5: assert property (tk && op_i == `SSTD_OP_BSUB_L5 |=> result_o == $past(r5)
      && flags_o[0] == !$past(b5)) else $error("short literal subtract wrong");
   AST_TBL_RD: assert property (tk && (op_i == `SSTD_OP_TRD_HI || op_i == `SSTD_OP_TRD_LO)
      |=> busy_o [*4] ##1 (done_o && wr_en_o && flags_we_o == 5'h00))
      else $error("table read timing wrong");
   AST_TBL_RDH: assert property (tk && op_i == `SSTD_OP_TRD_HI
      |-> ##5 result_o[7:0] == $past(prog_rdata_i[23:16])) else $error("high read data wrong");
   AST_TBL_WR: assert property (tk && (op_i == `SSTD_OP_TWR_HI || op_i == `SSTD_OP_TWR_LO)
      |=> busy_o ##1 (done_o && prog_we_o && !wr_en_o)) else $error("table write timing wrong");
   AST_PERIPH: assert property (tk && periph_i
      && (op_i == `SSTD_OP_BSUB_F || op_i == `SSTD_OP_RBSUB_F) |=> !done_o ##1 done_o)
      else $error("peripheral surcharge wrong");
   // Reverse form with literal minuend; carry out is the inverse of the borrow
   AST_RBSUB_L5: assert property (tk && op_i == `SSTD_OP_RBSUB_L5 |=> (done_o && wr_en_o
      && result_o == $past(d7[15:0]) && flags_o[0] == !$past(d7[16])))
      else $error("reverse literal subtract wrong");
   // Table writes must land the source bits in the right lane of the latch
   AST_TBL_WRH: assert property (tk && op_i == `SSTD_OP_TWR_HI |=> ##1 (prog_we_o
      && prog_wmask_o == 24'hff0000 && prog_wdata_o[23:16] == $past(opa_i[7:0], 2)))
      else $error("high table write data wrong");
   AST_TBL_WRL: assert property (tk && op_i == `SSTD_OP_TWR_LO |=> ##1 (prog_we_o
      && prog_wmask_o == 24'h00ffff && prog_wdata_o[15:0] == $past(opa_i, 2)))
      else $error("low table write data wrong");
endmodule
bind sstd_datapath sstd_datapath_checker #(.WIDTH(WIDTH), .PWIDTH(PWIDTH)) chk_u (.*);

// ==== bench/sstd_prog_model.sv ====
// Purpose: Program memory behind the table port
// Assumes: Addressing is outside the datapath
// Notes: Holds the word only while a read is in flight
`timescale 1ns/10ps
module sstd_prog_model (
   input wire ref_clk_i, // Clock
   input wire [23:0] word_i, // Addressed word
   input wire active_i, // Read in flight
   output wire [23:0] rdata_o // Read word
);
   logic [23:0] churn = 24'h5a5a5a;
   // Bus is not held outside a read, so a late sample sees a moving pattern
   always @(posedge ref_clk_i) churn <= churn + 24'h010101;
   assign rdata_o = active_i ? word_i : ~word_i ^ churn;
endmodule

// ==== bench/test_shift_subtract_table_access_datapath.sv ====
// Purpose: Self-checking bench for the datapath
// Assumes: Clock enable held high
// Notes: Hand-picked corners, then random ops from a fixed seed
`timescale 1ns/10ps
module test_shift_subtract_table_access_datapath;
   logic ref_clk_i = 0, rst_i = 1, op_valid_i = 0, periph_i = 0;
   logic [3:0] op_i = 4'h0;
   logic [15:0] opa_i = 16'h0000, opb_i = 16'h0000, result_o;
   logic [9:0] lit_i = 10'h000;
   logic [4:0] flags_i = 5'h00, flags_o, flags_we_o;
   logic [23:0] word = 24'h000000, prog_rdata_i, prog_wdata_o, prog_wmask_o;
   logic busy_o, done_o, wr_en_o, prog_we_o;
   int errors = 0, samples_checked = 0;
   // Instruction clock
   always #10 ref_clk_i = ~ref_clk_i;
   sstd_datapath dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .op_valid_i(op_valid_i), .op_i(op_i), .periph_i(periph_i), .opa_i(opa_i), .opb_i(opb_i),
      .lit_i(lit_i), .flags_i(flags_i), .prog_rdata_i(prog_rdata_i), .busy_o(busy_o),
      .done_o(done_o), .wr_en_o(wr_en_o), .result_o(result_o), .flags_o(flags_o),
      .flags_we_o(flags_we_o), .prog_we_o(prog_we_o), .prog_wdata_o(prog_wdata_o),
      .prog_wmask_o(prog_wmask_o));
   sstd_prog_model mem_u (.ref_clk_i(ref_clk_i), .word_i(word), .active_i(busy_o),
      .rdata_o(prog_rdata_i));
   task automatic cmp_data(input string nm, input logic [23:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   // Flags {digit carry,N,overflow,Z,C} above the difference; carry high means no borrow
   function automatic logic [20:0] sub(input logic [15:0] m, s, input logic c);
      logic [16:0] d;
      logic [4:0] n;
      d = {1'b0, m} - {1'b0, s} - {16'h0000, ~c};
      n = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, ~c};
      return {~n[4], d[15], m[15] != s[15] && d[15] != m[15], d[15:0] == 16'h0000, ~d[16], d[15:0]};
   endfunction
   function automatic logic [20:0] shl(input logic [15:0] a, input logic [4:0] k);
      logic [15:0] r;
      r = a << k;
      return {1'b0, r[15], 1'b0, r == 16'h0000, 1'b0, r};
   endfunction
   // Offer one op, wait for done under a bound, then check what it produced, only the low result byte of a high table read
   task automatic run(input logic [3:0] op, input logic [15:0] a, b, input logic [9:0] lit,
      input logic [4:0] fl, input logic per);
      logic [20:0] e;
      logic [4:0] mk;
      logic [23:0] wm;
      int n;
      int cyc;
      case (op)
         4'h1: e = shl(a, b[4:0]);
         4'h2: e = shl(a, lit[4:0]);
         4'h3: e = sub(a, b, fl[0]);
         4'h4: e = sub(a, {6'h00, lit}, fl[0]);
         4'h5: e = sub(a, {11'h000, lit[4:0]}, fl[0]);
         4'h6: e = sub(b, a, fl[0]);
         4'h7: e = sub({11'h000, lit[4:0]}, a, fl[0]);
         default: e = 21'h000000;
      endcase
      mk = (op < 4'h3) ? 5'h0a : (op < 4'h8) ? 5'h1f : 5'h00;
      cyc = (op > 4'h9) ? 2 : (op > 4'h7) ? 5 : (per && (op == 4'h3 || op == 4'h6)) ? 2 : 1;
      wm = (op == 4'ha) ? 24'hff0000 : 24'h00ffff;
      @(posedge ref_clk_i);
      op_valid_i <= 1'b1;
      op_i <= op;
      opa_i <= a;
      opb_i <= b;
      lit_i <= lit;
      flags_i <= fl;
      periph_i <= per;
      word <= 24'($urandom);
      @(posedge ref_clk_i);
      op_valid_i <= 1'b0;
      #1 n = 1;
      while (done_o !== 1'b1 && n < 20) begin
         @(posedge ref_clk_i);
         #1 n++;
      end
      cmp_data("cycles", 24'(cyc), 24'(n));
      cmp_data("flag mask", {19'h0, mk}, {19'h0, flags_we_o});
      cmp_data("strobes", {22'h0, op < 4'ha, op > 4'h9}, {22'h0, wr_en_o, prog_we_o});
      if (op < 4'h8) begin
         cmp_data("result", {8'h00, e[15:0]}, {8'h00, result_o});
         cmp_data("flags", {19'h0, e[20:16] & mk}, {19'h0, flags_o & flags_we_o});
      end
      if (op == 4'h8) cmp_data("read high", {16'h0, word[23:16]}, {16'h0, result_o[7:0]});
      if (op == 4'h9) cmp_data("read low", {8'h0, word[15:0]}, {8'h0, result_o});
      if (op > 4'h9) begin
         cmp_data("write mask", wm, prog_wmask_o);
         cmp_data("write data", {a[7:0], a} & wm, prog_wdata_o & prog_wmask_o);
      end
      $display("test op %h finished after %0d cycles", op, n);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence: corners first, then seeded random ops over codes 1 to 11
   initial begin
      void'($urandom(32'h1829));
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      #1 cmp_data("reset outputs", 24'h0, {done_o, wr_en_o, prog_we_o, flags_we_o, result_o});
      run(4'h1, 16'h8001, 16'h0010, 10'h000, 5'h00, 1'b0);
      run(4'h1, 16'h00ff, 16'h001f, 10'h000, 5'h1f, 1'b0);
      run(4'h2, 16'hc003, 16'h0000, 10'h3e1, 5'h1f, 1'b0);
      run(4'h4, 16'h0000, 16'h0000, 10'h000, 5'h00, 1'b0);
      run(4'h3, 16'h8000, 16'h0001, 10'h000, 5'h01, 1'b1);
      run(4'h6, 16'h1234, 16'h1234, 10'h000, 5'h01, 1'b1);
      for (int i = 0; i < 60; i++) begin
         run(4'($urandom_range(11, 1)), 16'($urandom), 16'($urandom), 10'($urandom),
            5'($urandom), 1'($urandom));
      end
      give_verdict;
   end
   // Hang guard, far beyond the expected run length
   initial begin
      #400000;
      errors++;
      give_verdict;
   end
endmodule
